// *** logic/mcfp_frame_parser.sv ***
module mcfp_frame_parser import mcfp_pkg::*; #(
  // clocks per serial bit; shorter only to keep simulations brief
  parameter int unsigned BIT_T = BIT_CYC,
  parameter int unsigned CNT_W = $clog2(BIT_T)
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // serial link
  input  wire logic        i_rxd,
  output logic             o_txd,
  // reply framing
  input  wire logic [7:0]  i_reply_addr,
  input  wire logic [7:0]  i_module_addr,
  input  wire logic        i_can_mode,
  // decoded command
  output logic             o_cmd_valid,
  output logic [7:0]       o_cmd_code,
  output logic [7:0]       o_cmd_type,
  output logic [7:0]       o_cmd_motor,
  output logic [31:0]      o_cmd_value,
  output logic             o_sum_err,
  output logic             o_busy,
  // command result
  input  wire logic        i_rsp_valid,
  input  wire logic [7:0]  i_rsp_status,
  input  wire logic [31:0] i_rsp_value
);

  mcfp_state_t       state_ff;
  mcfp_rx_t          rx_st_ff;
  logic [2:0]        sync_ff;
  logic              rxd_ff;
  logic [CNT_W-1:0]  rx_cnt_ff;
  logic [3:0]        rx_bit_ff;
  logic [7:0]        rx_sh_ff;
  logic              rx_byte_ok_ff;
  logic              rx_frm_err_ff;
  logic [71:0]       frm_sh_ff;
  logic [3:0]        frm_idx_ff;
  logic              cmd_valid_ff;
  logic [7:0]        cmd_code_ff;
  logic [7:0]        cmd_type_ff;
  logic [7:0]        cmd_motor_ff;
  logic [31:0]       cmd_value_ff;
  logic              sum_err_ff;
  logic              busy_ff;
  logic [7:0]        rep_status_ff;
  logic [71:0]       tx_frm_ff;
  logic [3:0]        tx_left_ff;
  logic [8:0]        tx_sh_ff;
  logic [3:0]        tx_bits_ff;
  logic [CNT_W-1:0]  tx_cnt_ff;
  logic              tx_act_ff;
  logic              txd_ff;

  assign o_txd       = txd_ff;
  assign o_cmd_valid = cmd_valid_ff;
  assign o_cmd_code  = cmd_code_ff;
  assign o_cmd_type  = cmd_type_ff;
  assign o_cmd_motor = cmd_motor_ff;
  assign o_cmd_value = cmd_value_ff;
  assign o_sum_err   = sum_err_ff;
  assign o_busy      = busy_ff;

  // receive side
  localparam int unsigned HALF_T = BIT_T / 2;
  wire rx_tick = rx_cnt_ff == CNT_W'(BIT_T - 1);
  wire rx_half = rx_cnt_ff == CNT_W'(HALF_T - 1);

  // filtered level changes only when stages two and three agree
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync_ff <= 3'h7;
      rxd_ff  <= 1'b1;
    end else begin
      sync_ff <= {sync_ff[1:0], i_rxd};
      if (sync_ff[1] == sync_ff[2]) begin
        rxd_ff <= sync_ff[2];
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rx_st_ff      <= RX_IDLE;
      rx_cnt_ff     <= '0;
      rx_bit_ff     <= 4'h0;
      rx_sh_ff      <= 8'h00;
      rx_byte_ok_ff <= 1'b0;
      rx_frm_err_ff <= 1'b0;
    end else begin
      rx_byte_ok_ff <= 1'b0;
      rx_frm_err_ff <= 1'b0;
      rx_cnt_ff     <= rx_cnt_ff + CNT_W'(1);
      case (rx_st_ff)
        RX_IDLE: begin
          rx_cnt_ff <= '0;
          if (!rxd_ff) begin
            rx_st_ff <= RX_START;
          end
        end
        RX_START: begin
          if (rx_half) begin
            rx_cnt_ff <= '0;
            rx_bit_ff <= 4'h0;
            rx_st_ff  <= rxd_ff ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_cnt_ff <= '0;
            rx_sh_ff  <= {rxd_ff, rx_sh_ff[7:1]};
            rx_bit_ff <= rx_bit_ff + 4'h1;
            if (rx_bit_ff == 4'(DATA_BITS - 1)) begin
              rx_st_ff <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            rx_st_ff      <= RX_IDLE;
            rx_byte_ok_ff <= rxd_ff;
            rx_frm_err_ff <= !rxd_ff;
          end
        end
        default: rx_st_ff <= RX_IDLE;
      endcase
    end
  end

  // frame assembly, bytes dropped while a reply is outstanding
  wire        in_recv   = state_ff == ST_RECV;
  wire [71:0] frm_full  = {frm_sh_ff[63:0], rx_sh_ff};
  wire        frm_last  = in_recv && rx_byte_ok_ff &&
                          frm_idx_ff == 4'(FRAME_LEN - 1);
  wire        sum_match = mcfp_sum8(frm_full[71:8]) ==
                          mcfp_byte(frm_full, IDX_SUM);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      frm_sh_ff  <= '0;
      frm_idx_ff <= 4'h0;
    end else if (!in_recv || rx_frm_err_ff) begin
      frm_idx_ff <= 4'h0;
    end else if (rx_byte_ok_ff) begin
      frm_sh_ff  <= frm_full;
      frm_idx_ff <= frm_last ? 4'h0 : frm_idx_ff + 4'h1;
    end
  end

  // reply build
  wire        rsp_take   = state_ff == ST_EXEC && i_rsp_valid;
  wire        bad_frame  = frm_last && !sum_match;
  wire        tx_load    = rsp_take || bad_frame;
  wire [7:0]  rep_status = rsp_take ? i_rsp_status : STATUS_BAD_SUM;
  wire [31:0] rep_value  = rsp_take ? i_rsp_value : 32'h00000000;
  wire [7:0]  rep_cmd    = rsp_take ? cmd_code_ff :
                           mcfp_byte(frm_full, IDX_CMD);
  wire [63:0] rep_body   = {i_reply_addr, i_module_addr, rep_status,
                            rep_cmd, rep_value};
  wire [71:0] rep_full   = {rep_body, mcfp_sum8(rep_body)};
  wire [71:0] rep_can    = {rep_body[55:0], 16'h0000};

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state_ff      <= ST_RECV;
      cmd_valid_ff  <= 1'b0;
      cmd_code_ff   <= 8'h00;
      cmd_type_ff   <= 8'h00;
      cmd_motor_ff  <= 8'h00;
      cmd_value_ff  <= 32'h00000000;
      sum_err_ff    <= 1'b0;
      busy_ff       <= 1'b0;
      rep_status_ff <= 8'h00;
    end else begin
      cmd_valid_ff <= frm_last && sum_match;
      sum_err_ff   <= bad_frame;
      busy_ff      <= (state_ff != ST_RECV) || frm_last;
      if (tx_load) begin
        rep_status_ff <= rep_status;
      end
      case (state_ff)
        ST_RECV: begin
          if (frm_last && sum_match) begin
            cmd_code_ff  <= mcfp_byte(frm_full, IDX_CMD);
            cmd_type_ff  <= mcfp_byte(frm_full, IDX_TYPE);
            cmd_motor_ff <= mcfp_byte(frm_full, IDX_MOTOR);
            cmd_value_ff <= frm_full[(FRAME_LEN-IDX_VAL)*8-1 -: 32];
            state_ff     <= ST_EXEC;
          end else if (bad_frame) begin
            state_ff <= ST_SEND;
          end
        end
        ST_EXEC: begin
          if (i_rsp_valid) begin
            state_ff <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (!tx_act_ff && tx_left_ff == 4'h0) begin
            state_ff <= ST_RECV;
          end
        end
        default: state_ff <= ST_RECV;
      endcase
    end
  end

  // transmit side, one idle cycle between bytes
  wire tx_tick = tx_cnt_ff == CNT_W'(BIT_T - 1);
  wire tx_next = state_ff == ST_SEND && !tx_act_ff && tx_left_ff != 4'h0;

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      tx_frm_ff  <= '0;
      tx_left_ff <= 4'h0;
      tx_sh_ff   <= 9'h1FF;
      tx_bits_ff <= 4'h0;
      tx_cnt_ff  <= '0;
      tx_act_ff  <= 1'b0;
      txd_ff     <= 1'b1;
    end else if (tx_load) begin
      tx_frm_ff  <= i_can_mode ? rep_can : rep_full;
      tx_left_ff <= i_can_mode ? 4'(CORE_LEN) : 4'(FRAME_LEN);
    end else if (tx_next) begin
      txd_ff     <= 1'b0;
      tx_sh_ff   <= {1'b1, tx_frm_ff[71:64]};
      tx_frm_ff  <= {tx_frm_ff[63:0], 8'h00};
      tx_left_ff <= tx_left_ff - 4'h1;
      tx_bits_ff <= 4'(DATA_BITS + STOP_BITS);
      tx_cnt_ff  <= '0;
      tx_act_ff  <= 1'b1;
    end else if (tx_act_ff) begin
      tx_cnt_ff <= tx_tick ? '0 : tx_cnt_ff + CNT_W'(1);
      if (tx_tick && tx_bits_ff == 4'h0) begin
        tx_act_ff <= 1'b0;
      end else if (tx_tick) begin
        txd_ff     <= tx_sh_ff[0];
        tx_sh_ff   <= {1'b1, tx_sh_ff[8:1]};
        tx_bits_ff <= tx_bits_ff - 4'h1;
      end
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  sequence s_load;
    tx_load && !i_can_mode;
  endsequence

  a_tx_bit_time: assert property (tx_cnt_ff <= CNT_W'(BIT_T - 1))
    else $error("tx bit counter beyond bit time");
  a_tx_idle_high: assert property (
    state_ff == ST_RECV |-> txd_ff)
    else $error("line not idle high outside reply");
  a_frame_nine: assert property (
    cmd_valid_ff |-> $past(frm_idx_ff) == 4'(FRAME_LEN - 1))
    else $error("command taken before ninth byte");
  a_cmd_sum_ok: assert property (
    cmd_valid_ff |-> $past(sum_match) && !sum_err_ff)
    else $error("command issued on bad checksum");
  a_bad_no_exec: assert property (
    sum_err_ff |-> !cmd_valid_ff && state_ff == ST_SEND &&
    rep_status_ff != STATUS_OK)
    else $error("bad frame executed or reported ok");
  a_one_reply: assert property (
    cmd_valid_ff |-> state_ff == ST_EXEC && !tx_act_ff)
    else $error("command without pending reply");
  a_reply_load: assert property (
    rsp_take |=> state_ff == ST_SEND && tx_left_ff != 4'h0)
    else $error("result taken without reply load");
  a_reply_order: assert property (
    s_load |=> tx_frm_ff[71:64] == $past(i_reply_addr) &&
    tx_frm_ff[63:56] == $past(i_module_addr))
    else $error("reply address bytes misplaced");
  a_reply_sum: assert property (
    s_load |=> tx_frm_ff[7:0] == mcfp_sum8(tx_frm_ff[71:8]) &&
    tx_left_ff == 4'(FRAME_LEN))
    else $error("reply checksum wrong");
  a_can_short: assert property (
    tx_load && i_can_mode |=> tx_left_ff == 4'(CORE_LEN) &&
    tx_frm_ff[71:64] == $past(i_module_addr))
    else $error("can reply not shortened");
  a_drop_busy: assert property (
    !in_recv |=> frm_idx_ff == 4'h0)
    else $error("bytes assembled while busy");

endmodule

// *** logic/mcfp_pkg.sv ***
// Operation
// - link is 8N1 at 38400 baud
// - command core is seven bytes
// - address plus core plus checksum: nine bytes
// - address, command, type, motor, value MSB-first, checksum
// - checksum is 8-bit sum of eight bytes
// - one reply per received command frame
// - reply: raddr, maddr, status, command, value, checksum
// - reply checksum sums its eight bytes
// - CAN mode drops reply address and checksum
package mcfp_pkg;

  localparam int unsigned CLK_HZ    = 25_000_000;
  localparam int unsigned BAUD      = 38_400;
  // longest bit time rounds down
  localparam int unsigned BIT_CYC   = CLK_HZ / BAUD;
  localparam int unsigned HALF_CYC  = BIT_CYC / 2;
  localparam int unsigned DATA_BITS = 8;
  localparam int unsigned STOP_BITS = 1;

  localparam int unsigned FRAME_LEN = 9;
  localparam int unsigned CORE_LEN  = 7;
  localparam int unsigned IDX_ADDR  = 0;
  localparam int unsigned IDX_CMD   = 1;
  localparam int unsigned IDX_TYPE  = 2;
  localparam int unsigned IDX_MOTOR = 3;
  localparam int unsigned IDX_VAL   = 4;
  localparam int unsigned IDX_SUM   = 8;

  localparam logic [7:0] STATUS_OK      = 8'h64;
  localparam logic [7:0] STATUS_BAD_SUM = 8'h01;

  typedef enum logic [1:0] {ST_RECV, ST_EXEC, ST_SEND} mcfp_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} mcfp_rx_t;

  function automatic logic [7:0] mcfp_sum8(input logic [63:0] b);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++) begin
      s = s + b[i*8 +: 8];
    end
    return s;
  endfunction

  // byte k of a frame, byte 0 in the top bits
  function automatic logic [7:0] mcfp_byte(input logic [71:0] f,
                                           input int unsigned k);
    return f[(FRAME_LEN - 1 - k)*8 +: 8];
  endfunction

endpackage

// *** testbench/mcfp_frame_parser_tb_top.sv ***
module mcfp_frame_parser_tb_top import mcfp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // short bit time keeps the run brief; same logic as the full rate
  localparam int unsigned TB_BIT = 20;

  logic        clk, rst, rxd, txd, can_mode, rsp_valid;
  logic        cmd_valid, sum_err, busy, byte_stb, stop_bad;
  logic [7:0]  reply_addr, module_addr, rsp_status;
  logic [7:0]  cmd_code, cmd_type, cmd_motor, rx_byte;
  logic [31:0] cmd_value, rsp_value;
  logic [7:0]  exp_q[$];
  logic [71:0] cmd_q[$];
  int          fails, cmp_count, err_exp, cycles;

  mcfp_frame_parser #(.BIT_T(TB_BIT)) i_dut (
    .i_clk(clk), .i_sys_rst(rst), .i_rxd(rxd), .o_txd(txd),
    .i_reply_addr(reply_addr), .i_module_addr(module_addr),
    .i_can_mode(can_mode), .o_cmd_valid(cmd_valid),
    .o_cmd_code(cmd_code), .o_cmd_type(cmd_type),
    .o_cmd_motor(cmd_motor), .o_cmd_value(cmd_value),
    .o_sum_err(sum_err), .o_busy(busy), .i_rsp_valid(rsp_valid),
    .i_rsp_status(rsp_status), .i_rsp_value(rsp_value));

  mcfp_host_model #(.BIT_T(TB_BIT)) i_host (
    .i_clk(clk), .i_txd(txd), .o_rxd(rxd),
    .o_byte_stb(byte_stb), .o_byte(rx_byte), .o_stop_bad(stop_bad));

  function automatic logic [7:0] add8(input logic [71:0] f);
    logic [7:0] s;
    s = 8'h00;
    for (int k = 0; k < 8; k++) begin
      s = s + f[71-8*k -: 8];
    end
    return s;
  endfunction

  task automatic check(input logic [71:0] got, input logic [71:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report;
    $display("compares=%0d mismatches=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // two frames and replies take about 7k cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      final_report();
    end
  end

  // oldest note against each result; an unexpected one meets 'x
  always @(posedge clk) begin
    if (byte_stb === 1'b1)
      check(rx_byte, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
  end

  // design pulses looked at mid-cycle, clear of the launching edge
  always @(negedge clk) begin
    if (cmd_valid === 1'b1)
      check({cmd_code, cmd_type, cmd_motor, cmd_value},
            cmd_q.size() > 0 ? cmd_q.pop_front() : 'x);
    if (sum_err === 1'b1) begin
      check(err_exp, 1);
      err_exp--;
    end
  end

  // result answers each decoded command half a cycle later
  initial forever begin
    @(negedge clk iff cmd_valid === 1'b1);
    rsp_valid = 1'b1;
    @(negedge clk);
    rsp_valid = 1'b0;
  end

  task automatic run_frame(input logic [71:0] f, input logic can,
                           input logic good, input logic junk);
    logic [71:0] r;
    r = {reply_addr, module_addr, good ? rsp_status : STATUS_BAD_SUM,
         f[63:56], good ? rsp_value : 32'h0000_0000, 8'h00};
    r[7:0] = add8(r);
    for (int k = 0; k < 9; k++) begin
      if (!can || (k > 0 && k < 8)) exp_q.push_back(r[71-8*k -: 8]);
    end
    if (good) cmd_q.push_back({16'h0000, f[63:8]});
    else err_exp++;
    can_mode = can;
    i_host.send_frame(f);
    if (junk) begin
      check(busy, 1);
      // bytes while busy must be dropped, else the next frame slips
      i_host.send_byte(8'hA5);
      i_host.send_byte(8'h3C);
    end
    // host waits for the whole reply before the next frame
    for (int n = 0; n < 4000 && exp_q.size() > 0; n++)
      @(negedge clk);
    // last byte is taken mid stop bit; the rest of it still runs
    repeat (TB_BIT + 4) @(negedge clk);
    check(exp_q.size(), 0);
    check(busy, 0);
  endtask

  initial begin
    logic [71:0] f;
    void'($urandom(42735));
    rst = 1'b1;
    can_mode = 1'b0;
    rsp_valid = 1'b0;
    reply_addr = 8'($urandom);
    module_addr = 8'($urandom);
    rsp_status = 8'($urandom);
    rsp_value = $urandom;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    f = {$urandom, $urandom, 8'h00};
    f[7:0] = add8(f);
    run_frame(f, 1'b0, 1'b1, 1'b1);
    f = {$urandom, $urandom, 8'h00};
    f[7:0] = add8(f) + 8'h01;
    run_frame(f, 1'b1, 1'b0, 1'b0);
    repeat (TB_BIT * 11) @(negedge clk);
    check(stop_bad, 0);
    check(err_exp, 0);
    check(cmd_q.size(), 0);
    final_report();
  end
endmodule

// *** testbench/mcfp_host_model.sv ***
// host side of the serial link, 8N1 both ways
module mcfp_host_model import mcfp_pkg::*; #(
  parameter int unsigned BIT_T = BIT_CYC
) (
  // clock
  input  wire logic       i_clk,
  // serial link
  input  wire logic       i_txd,
  output logic            o_rxd,
  // received reply bytes
  output logic            o_byte_stb,
  output logic [7:0]      o_byte,
  output logic            o_stop_bad
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] rx_sh;

  initial begin
    o_rxd      = 1'b1;
    o_byte_stb = 1'b0;
    o_byte     = 8'h00;
    o_stop_bad = 1'b0;
  end

  // caller enters on a falling edge; line left high after stop bit
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] sh;
    sh = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      o_rxd = sh[i];
      repeat (BIT_T) @(negedge i_clk);
    end
  endtask

  // whole frames only, byte 0 first
  task automatic send_frame(input logic [71:0] f);
    for (int k = 0; k < 9; k++) begin
      send_byte(f[71-8*k -: 8]);
    end
  endtask

  // mid-bit sampling, stop bit must be high
  always begin
    @(negedge i_txd);
    repeat (BIT_T / 2) @(posedge i_clk);
    if (i_txd == 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_T) @(posedge i_clk);
        rx_sh[i] = i_txd;
      end
      repeat (BIT_T) @(posedge i_clk);
      if (i_txd !== 1'b1) begin
        o_stop_bad = 1'b1;
      end
      @(negedge i_clk);
      o_byte     = rx_sh;
      o_byte_stb = 1'b1;
      @(negedge i_clk);
      o_byte_stb = 1'b0;
    end
  end
endmodule
